// ===== common/iucf_defines.svh
// constants for the infrared port configuration bank: offsets, fields, resets, divider counts
`ifndef IUCF_DEFINES_SVH
`define IUCF_DEFINES_SVH

// ----------------------------------------------------------------
// banked register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IUCF_IDX_SELECTOR 3'h3
`define IUCF_IDX_ADV_DIV_LO 3'h0
`define IUCF_IDX_ADV_DIV_HI 3'h1
`define IUCF_IDX_ADV_CTRL_ONE 3'h2
`define IUCF_IDX_ADV_CTRL_TWO 3'h4
`define IUCF_IDX_TX_FILL 3'h6
`define IUCF_IDX_RX_FILL 3'h7
`define IUCF_IDX_VERSION 3'h0
`define IUCF_IDX_MIRROR_IRC 3'h1
`define IUCF_IDX_MIRROR_FIFO 3'h2
`define IUCF_IDX_LEG_DIV_LO 3'h0
`define IUCF_IDX_LEG_DIV_HI 3'h1
`define IUCF_IDX_FIFO_CTRL 3'h2
`define IUCF_IDX_IR_CTRL 3'h4

// ----------------------------------------------------------------
// selector codes, also the constant read back in those sets
// ----------------------------------------------------------------
`define IUCF_SEL_SET_TWO 8'he0
`define IUCF_SEL_SET_THREE 8'he4

// ----------------------------------------------------------------
// field positions, masks and reset values
// ----------------------------------------------------------------
`define IUCF_INHIBIT_BIT 7
`define IUCF_ADV_MODE_BIT 0
`define IUCF_RESERVED6_MASK 8'hbf
`define IUCF_FALLBACK_KEEP 8'h5e
`define IUCF_SIZE_32 2'b01
`define IUCF_RESET_BYTE 8'h00

// ----------------------------------------------------------------
// pre-divider ratios in eighths of a reference cycle, fifo depths
// ----------------------------------------------------------------
`define IUCF_PRE_STEP 7'd8
`define IUCF_PRE_DIV_13 7'd104
`define IUCF_PRE_DIV_1625 7'd13
`define IUCF_PRE_DIV_65 7'd52
`define IUCF_PRE_DIV_1 7'd8
`define IUCF_DEPTH_16 6'd16
`define IUCF_DEPTH_32 6'd32

`endif

// ===== common/iucf_pkg.sv
// types shared by the infrared port configuration bank
package iucf_pkg;

  // ----------------------------------------------------------------
  // register set currently mapped onto the eight offsets
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IUCF_BANK_BASE  = 3'b001,
    IUCF_BANK_TWO   = 3'b010,
    IUCF_BANK_THREE = 3'b100
  } iucf_bank_type;

  // ----------------------------------------------------------------
  // complete state of the configuration block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctlTwo;
    logic [7:0] ctlOne;
    logic [7:0] advDivLo;
    logic [7:0] advDivHi;
    logic [7:0] legDivLo;
    logic [7:0] legDivHi;
    logic [7:0] fifoCtl;
    logic [7:0] irCtl;
    logic [7:0] bankSel;
    logic [5:0] txFill;
    logic [5:0] rxFill;
    logic [5:0] txDepth;
    logic [5:0] rxDepth;
    logic [6:0] preAcc;
    logic [15:0] baudCnt;
    logic refPrev;
    logic preTick;
    logic baudTick;
    logic fallbackEvt;
    logic pend;
    logic pendWrite;
    logic [2:0] pendIdx;
    logic readyOut;
    logic [7:0] rdata;
  } iucf_state_type;

endpackage : iucf_pkg

// ===== logic/iucf_config.sv
// infrared port configuration bank: set selector, control two, fill counters, version set
`timescale 1ns/1ps
`include "iucf_defines.svh"

module iucf_config
  import iucf_pkg::*;
#(
  parameter logic [7:0] VERSION_ID = 8'h5a // arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic refClk,
  input wire logic txLoad,
  input wire logic txDrain,
  input wire logic rxLoad,
  input wire logic rxDrain,
  output logic baudTick,
  output logic advancedMode,
  output logic fallbackInhibit,
  output logic fallbackEvt,
  output logic [5:0] txDepth,
  output logic [5:0] rxDepth
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // selector values other than the two set codes map the base set
  function automatic iucf_bank_type bankOf(input logic [7:0] sel);
    if (sel == `IUCF_SEL_SET_TWO) begin
      return IUCF_BANK_TWO;
    end else if (sel == `IUCF_SEL_SET_THREE) begin
      return IUCF_BANK_THREE;
    end
    return IUCF_BANK_BASE;
  endfunction : bankOf

  // saturating fill count; a shrunken depth clamps the count
  function automatic logic [5:0] fillStep(input logic [5:0] fill, input logic load,
                                          input logic drain, input logic [5:0] depth);
    logic [5:0] res;
    res = fill;
    if (load && !drain && fill < depth) begin
      res = fill + 6'd1;
    end else if (drain && !load && fill != 6'd0) begin
      res = fill - 6'd1;
    end
    if (res > depth) begin
      res = depth;
    end
    return res;
  endfunction : fillStep

  // reserved codes fall to 16 bytes so threshold logic stays defined
  function automatic logic [5:0] depthOf(input logic [1:0] code);
    return (code == `IUCF_SIZE_32) ? `IUCF_DEPTH_32 : `IUCF_DEPTH_16;
  endfunction : depthOf

  iucf_state_type st_r;
  iucf_state_type st_nxt;
  logic refEdge;
  logic [6:0] preDiv;
  logic [6:0] preSum;
  logic [15:0] divisor;
  logic [15:0] divEff;
  logic legacyHit;
  logic [7:0] wbyte;
  iucf_bank_type curBank;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.preTick = 1'b0;
    st_nxt.baudTick = 1'b0;
    st_nxt.fallbackEvt = 1'b0;
    refEdge = refClk & ~st_r.refPrev;
    st_nxt.refPrev = refClk;
    wbyte = hwdata[7:0];
    curBank = bankOf(st_r.bankSel);

    // fractional pre-divider: step eight per reference edge against ratio in eighths
    unique case (st_r.ctlTwo[5:4])
      2'b00: preDiv = `IUCF_PRE_DIV_13;
      2'b01: preDiv = `IUCF_PRE_DIV_1625;
      2'b10: preDiv = `IUCF_PRE_DIV_65;
      2'b11: preDiv = `IUCF_PRE_DIV_1;
    endcase
    preSum = st_r.preAcc + `IUCF_PRE_STEP;
    if (refEdge) begin
      if (preSum >= preDiv) begin
        st_nxt.preAcc = preSum - preDiv;
        st_nxt.preTick = 1'b1;
      end else begin
        st_nxt.preAcc = preSum;
      end
    end

    // baud divisor counts pre-divided ticks; zero acts as one to avoid a stuck counter
    divisor = st_r.ctlOne[`IUCF_ADV_MODE_BIT] ? {st_r.advDivHi, st_r.advDivLo}
                                              : {st_r.legDivHi, st_r.legDivLo};
    divEff = (divisor == 16'h0000) ? 16'h0001 : divisor;
    if (st_r.preTick) begin
      if (st_r.baudCnt >= divEff - 16'h0001) begin
        st_nxt.baudCnt = 16'h0000;
        st_nxt.baudTick = 1'b1;
      end else begin
        st_nxt.baudCnt = st_r.baudCnt + 16'h0001;
      end
    end

    // depths follow the size codes one cycle later
    st_nxt.rxDepth = depthOf(st_r.ctlTwo[3:2]);
    st_nxt.txDepth = depthOf(st_r.ctlTwo[1:0]);
    st_nxt.txFill = fillStep(st_r.txFill, txLoad, txDrain, st_r.txDepth);
    st_nxt.rxFill = fillStep(st_r.rxFill, rxLoad, rxDrain, st_r.rxDepth);

    // bus: one wait state, the access executes in the data phase
    legacyHit = 1'b0;
    if (st_r.pend) begin
      st_nxt.pend = 1'b0;
      st_nxt.readyOut = 1'b1;
      st_nxt.rdata = `IUCF_RESET_BYTE;
      legacyHit = (curBank == IUCF_BANK_BASE) && (st_r.pendIdx <= `IUCF_IDX_LEG_DIV_HI);
      // divisor latch access without inhibit falls back, clearing ctlOne bits 0, 5 and 7
      if (legacyHit && !st_r.ctlTwo[`IUCF_INHIBIT_BIT]) begin
        st_nxt.ctlOne = st_r.ctlOne & `IUCF_FALLBACK_KEEP;
        st_nxt.fallbackEvt = 1'b1;
      end
      if (st_r.pendIdx == `IUCF_IDX_SELECTOR) begin
        if (st_r.pendWrite) begin
          st_nxt.bankSel = wbyte;
        end
        unique case (curBank)
          IUCF_BANK_TWO: st_nxt.rdata = `IUCF_SEL_SET_TWO;
          IUCF_BANK_THREE: st_nxt.rdata = `IUCF_SEL_SET_THREE;
          IUCF_BANK_BASE: st_nxt.rdata = st_r.bankSel;
        endcase
      end else begin
        unique case (curBank)
          IUCF_BANK_TWO: begin
            unique case (st_r.pendIdx)
              `IUCF_IDX_ADV_DIV_LO: begin
                st_nxt.rdata = st_r.advDivLo;
                if (st_r.pendWrite) st_nxt.advDivLo = wbyte;
              end
              `IUCF_IDX_ADV_DIV_HI: begin
                st_nxt.rdata = st_r.advDivHi;
                if (st_r.pendWrite) st_nxt.advDivHi = wbyte;
              end
              `IUCF_IDX_ADV_CTRL_ONE: begin
                st_nxt.rdata = st_r.ctlOne;
                if (st_r.pendWrite) st_nxt.ctlOne = wbyte & `IUCF_RESERVED6_MASK;
              end
              `IUCF_IDX_ADV_CTRL_TWO: begin
                st_nxt.rdata = st_r.ctlTwo;
                if (st_r.pendWrite) st_nxt.ctlTwo = wbyte & `IUCF_RESERVED6_MASK;
              end
              `IUCF_IDX_TX_FILL: st_nxt.rdata = {2'b00, st_r.txFill};
              `IUCF_IDX_RX_FILL: st_nxt.rdata = {2'b00, st_r.rxFill};
              default: st_nxt.rdata = `IUCF_RESET_BYTE;
            endcase
          end
          IUCF_BANK_THREE: begin
            // every offset here is read only; writes are dropped
            unique case (st_r.pendIdx)
              `IUCF_IDX_VERSION: st_nxt.rdata = VERSION_ID;
              `IUCF_IDX_MIRROR_IRC: st_nxt.rdata = st_r.irCtl;
              `IUCF_IDX_MIRROR_FIFO: st_nxt.rdata = st_r.fifoCtl;
              default: st_nxt.rdata = `IUCF_RESET_BYTE;
            endcase
          end
          IUCF_BANK_BASE: begin
            unique case (st_r.pendIdx)
              `IUCF_IDX_LEG_DIV_LO: begin
                st_nxt.rdata = st_r.legDivLo;
                if (st_r.pendWrite) st_nxt.legDivLo = wbyte;
              end
              `IUCF_IDX_LEG_DIV_HI: begin
                st_nxt.rdata = st_r.legDivHi;
                if (st_r.pendWrite) st_nxt.legDivHi = wbyte;
              end
              `IUCF_IDX_FIFO_CTRL: begin
                st_nxt.rdata = st_r.fifoCtl;
                if (st_r.pendWrite) st_nxt.fifoCtl = wbyte;
              end
              `IUCF_IDX_IR_CTRL: begin
                st_nxt.rdata = st_r.irCtl;
                if (st_r.pendWrite) st_nxt.irCtl = wbyte;
              end
              default: st_nxt.rdata = `IUCF_RESET_BYTE;
            endcase
          end
        endcase
      end
    end else if (hsel && hready && htrans[1]) begin
      st_nxt.pend = 1'b1;
      st_nxt.pendWrite = hwrite;
      st_nxt.pendIdx = haddr[4:2];
      st_nxt.readyOut = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.rxDepth <= `IUCF_DEPTH_16;
      st_r.txDepth <= `IUCF_DEPTH_16;
      st_r.readyOut <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register, except hresp, which is tied low
  assign hrdata = {24'h000000, st_r.rdata};
  assign hreadyout = st_r.readyOut;
  assign hresp = 1'b0; // always okay
  assign baudTick = st_r.baudTick;
  assign advancedMode = st_r.ctlOne[`IUCF_ADV_MODE_BIT];
  assign fallbackInhibit = st_r.ctlTwo[`IUCF_INHIBIT_BIT];
  assign fallbackEvt = st_r.fallbackEvt;
  assign txDepth = st_r.txDepth;
  assign rxDepth = st_r.rxDepth;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic execRead;
  logic execAny;
  assign execRead = st_r.pend && !st_r.pendWrite;
  assign execAny = st_r.pend;

  selTwoRead_a: assert property (execRead && curBank == IUCF_BANK_TWO && st_r.pendIdx == 3'h3
    |=> st_r.rdata == 8'he0 && st_r.readyOut) else $error("set two selector read wrong");
  selThreeRead_a: assert property (execRead && curBank == IUCF_BANK_THREE
    && st_r.pendIdx == 3'h3 |=> st_r.rdata == 8'he4) else $error("set three selector wrong");
  bankWrite_a: assert property (execAny && st_r.pendWrite && st_r.pendIdx == 3'h3
    |=> st_r.bankSel == $past(hwdata[7:0])) else $error("selector write lost");
  inhibitKeep_a: assert property (legacyHit && st_r.ctlTwo[7]
    |=> st_r.ctlOne == $past(st_r.ctlOne) && !st_r.fallbackEvt) else $error("inhibit ignored");
  fallbackDrop_a: assert property (legacyHit && !st_r.ctlTwo[7]
    |=> !st_r.ctlOne[0] && !st_r.ctlOne[5] && !st_r.ctlOne[7] && st_r.fallbackEvt)
    else $error("fallback missing");
  prescaleOne_a: assert property (refClk && !st_r.refPrev && st_r.ctlTwo[5:4] == 2'b11
    |=> st_r.preTick) else $error("undivided tick missing");
  // a code rewritten just after a tick may tick sooner, so only code 00 cycles are held
  prescaleThirteen_a: assert property (st_r.preTick && st_r.ctlTwo[5:4] == 2'b00
    && $stable(st_r.ctlTwo) |=> (!st_r.preTick || st_r.ctlTwo[5:4] != 2'b00) [*8])
    else $error("pre tick too early");
  baudTick_a: assert property (st_r.preTick && st_r.baudCnt >= divEff - 16'h0001
    |=> st_r.baudTick && st_r.baudCnt == 16'h0000) else $error("baud tick missing");
  rxDepth_a: assert property (##1 st_r.rxDepth == (($past(st_r.ctlTwo[3:2]) == 2'b01)
    ? 6'd32 : 6'd16)) else $error("rx depth wrong");
  txDepth_a: assert property (##1 st_r.txDepth == (($past(st_r.ctlTwo[1:0]) == 2'b01)
    ? 6'd32 : 6'd16)) else $error("tx depth wrong");
  txFillRead_a: assert property (execRead && curBank == IUCF_BANK_TWO && st_r.pendIdx == 3'h6
    |=> st_r.rdata == {2'b00, $past(st_r.txFill)}) else $error("tx fill read wrong");
  rxFillRead_a: assert property (execRead && curBank == IUCF_BANK_TWO && st_r.pendIdx == 3'h7
    |=> st_r.rdata == {2'b00, $past(st_r.rxFill)}) else $error("rx fill read wrong");
  versionRead_a: assert property (execRead && curBank == IUCF_BANK_THREE && st_r.pendIdx == 3'h0
    |=> st_r.rdata == VERSION_ID) else $error("version read wrong");
  mirrorRead_a: assert property (execRead && curBank == IUCF_BANK_THREE && st_r.pendIdx == 3'h1
    |=> st_r.rdata == $past(st_r.irCtl)) else $error("mirror read wrong");

  fallbackSeen_c: cover property (legacyHit && !st_r.ctlTwo[7] && st_r.ctlOne[0]);
  setThreeRead_c: cover property (execRead && curBank == IUCF_BANK_THREE);
  baudRun_c: cover property (st_r.baudTick ##[1:200] st_r.baudTick);
  fillFull_c: cover property (st_r.rxFill == st_r.rxDepth && st_r.rxDepth == 6'd32);

endmodule : iucf_config

// ===== verification/iucf_ir_partner.sv
// reference clock source standing in for the transceiver side's 24 MHz input
`timescale 1ns/1ps

module iucf_ir_partner (
  output logic refClk
);
  // ----------------------------------------------------------------
  // free-running reference, phase unrelated to the system clock
  // ----------------------------------------------------------------
  // odd start offset so reference edges never line up with clk edges
  initial begin
    refClk = 1'b0;
    #7.3;
    forever #20.833 refClk = ~refClk;
  end
endmodule : iucf_ir_partner

// ===== verification/tb_iucf_config.sv
// self-checking bench for the infrared port configuration bank
`timescale 1ns/1ps
`include "iucf_defines.svh"

module tb_iucf_config
  import iucf_pkg::*;
;
  typedef struct packed {logic [2:0] idx; logic wr; logic [7:0] d;} iucf_row_type;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic txLoad = 1'b0;
  logic txDrain = 1'b0;
  logic rxLoad = 1'b0;
  logic rxDrain = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, refClk, baudTick, advancedMode, fallbackInhibit, fallbackEvt;
  logic [5:0] txDepth, rxDepth;
  int num_errors = 0;
  int check_count = 0;
  int fbCount = 0;
  int tickCount = 0;
  int n;
  // reads carry the expected byte in d, writes carry the data
  iucf_row_type rows [18] = '{
    {3'h4, 1'b1, 8'h5c}, {3'h2, 1'b1, 8'h87},
    {3'h3, 1'b1, `IUCF_SEL_SET_THREE},
    {3'h0, 1'b0, 8'h3c},
    {3'h1, 1'b0, 8'h5c}, {3'h2, 1'b0, 8'h87},
    {3'h3, 1'b0, 8'he4},
    {3'h1, 1'b1, 8'h00}, {3'h1, 1'b0, 8'h5c},
    {3'h4, 1'b1, 8'h33}, {3'h4, 1'b0, 8'h00},
    {3'h3, 1'b1, `IUCF_SEL_SET_TWO},
    {3'h3, 1'b0, 8'he0},
    {3'h4, 1'b1, 8'hff}, {3'h4, 1'b0, 8'hbf},
    {3'h6, 1'b1, 8'h12}, {3'h6, 1'b0, 8'h00},
    {3'h7, 1'b0, 8'h00}};
  logic [7:0] dcode [4] = '{8'h05, 8'h0a, 8'h0f, 8'h04};
  logic [1:0] bcode [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [7:0] bdiv [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h04};
  int bexp [5] = '{8, 64, 16, 104, 26};

  // ----------------------------------------------------------------
  // design, reference source, clock
  // ----------------------------------------------------------------
  iucf_config #(.VERSION_ID(8'h3c)) dut_u ( // version value is arbitrary
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .refClk(refClk),
    .txLoad(txLoad), .txDrain(txDrain), .rxLoad(rxLoad), .rxDrain(rxDrain),
    .baudTick(baudTick), .advancedMode(advancedMode), .fallbackInhibit(fallbackInhibit),
    .fallbackEvt(fallbackEvt), .txDepth(txDepth), .rxDepth(rxDepth));
  iucf_ir_partner ref_u (.refClk(refClk));
  always #10 clk = ~clk;

  // pulse counters; old values are sampled at the edge, so no race with the design
  always @(posedge clk) begin
    if (fallbackEvt === 1'b1) fbCount++;
    if (baudTick === 1'b1) tickCount++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one single word transfer; waits on ready in both phases, data taken at the last edge
  task automatic xfer(input logic [2:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {27'h0, idx, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  // n consecutive one-cycle strobes of the fifo byte events
  task automatic push(input logic [3:0] m, input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      {txLoad, txDrain, rxLoad, rxDrain} <= m;
    end
    @(posedge clk);
    {txLoad, txDrain, rxLoad, rxDrain} <= 4'h0;
  endtask : push

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // watchdog: the whole run needs well under 100 us
  initial begin
    #400000;
    num_errors++;
    $display("timeout at %0t", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 18; i++) begin
      xfer(rows[i].idx, rows[i].wr, rows[i].d);
      if (!rows[i].wr) chk(rd, {24'h0, rows[i].d});
    end
    $display("test register map done");
    for (int i = 0; i < 4; i++) begin
      xfer(`IUCF_IDX_ADV_CTRL_TWO, 1'b1, dcode[i]);
      @(posedge clk);
      chk({26'h0, rxDepth}, (dcode[i][3:2] == 2'b01) ? 32'd32 : 32'd16);
      chk({26'h0, txDepth}, (dcode[i][1:0] == 2'b01) ? 32'd32 : 32'd16);
    end
    $display("test fifo depths done");
    // tx saturates at 16, rx ends at 19 after drains, simultaneous load and drain on tx
    push(4'b1000, 20);
    push(4'b0010, 20);
    push(4'b0001, 3);
    push(4'b1110, 2);
    xfer(`IUCF_IDX_TX_FILL, 1'b0, 8'h00);
    chk(rd, 32'h10);
    xfer(`IUCF_IDX_RX_FILL, 1'b0, 8'h00);
    chk(rd, 32'h13);
    push(4'b0100, 17);
    xfer(`IUCF_IDX_TX_FILL, 1'b0, 8'h00);
    chk(rd, 32'h00);
    $display("test fill counters done");
    xfer(`IUCF_IDX_ADV_CTRL_TWO, 1'b1, 8'h04);
    xfer(`IUCF_IDX_ADV_CTRL_ONE, 1'b1, 8'ha3);
    n = fbCount;
    xfer(`IUCF_IDX_SELECTOR, 1'b1, 8'h00);
    xfer(`IUCF_IDX_LEG_DIV_LO, 1'b0, 8'h00);
    @(posedge clk);
    chk(fbCount - n, 32'd1);
    chk({31'h0, advancedMode}, 32'h0);
    xfer(`IUCF_IDX_SELECTOR, 1'b1, `IUCF_SEL_SET_TWO);
    xfer(`IUCF_IDX_ADV_CTRL_ONE, 1'b0, 8'h00);
    chk(rd, 32'h02);
    xfer(`IUCF_IDX_ADV_CTRL_TWO, 1'b1, 8'h84);
    xfer(`IUCF_IDX_ADV_CTRL_ONE, 1'b1, 8'ha3);
    n = fbCount;
    xfer(`IUCF_IDX_SELECTOR, 1'b1, 8'h00);
    xfer(`IUCF_IDX_LEG_DIV_HI, 1'b1, 8'h00);
    @(posedge clk);
    chk(fbCount - n, 32'd0);
    chk({30'h0, advancedMode, fallbackInhibit}, 32'h3);
    xfer(`IUCF_IDX_SELECTOR, 1'b1, `IUCF_SEL_SET_TWO);
    xfer(`IUCF_IDX_ADV_CTRL_ONE, 1'b0, 8'h00);
    chk(rd, 32'ha3);
    $display("test fallback done");
    // ticks over 104 reference periods; one tick of slack for window phase
    for (int i = 0; i < 5; i++) begin
      xfer(`IUCF_IDX_ADV_DIV_LO, 1'b1, bdiv[i]);
      xfer(`IUCF_IDX_ADV_CTRL_TWO, 1'b1, {2'b10, bcode[i], 4'h0});
      #1000;
      n = tickCount;
      #4333.33;
      n = tickCount - n;
      check_count++;
      if (n < bexp[i] - 1 || n > bexp[i] + 1) begin
        num_errors++;
        $display("mismatch at %0t: got %h expected %h", $time, n, bexp[i]);
      end
    end
    $display("test baud prescale done");
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk({hreadyout, hresp, advancedMode, fallbackInhibit, baudTick}, 5'b10000);
    chk({txDepth, rxDepth}, {6'd16, 6'd16});
    rstn <= 1'b1;
    xfer(`IUCF_IDX_SELECTOR, 1'b1, `IUCF_SEL_SET_TWO);
    xfer(`IUCF_IDX_ADV_CTRL_TWO, 1'b0, 8'h00);
    chk(rd, 32'h00);
    xfer(`IUCF_IDX_ADV_CTRL_ONE, 1'b0, 8'h00);
    chk(rd, 32'h00);
    xfer(`IUCF_IDX_RX_FILL, 1'b0, 8'h00);
    chk(rd, 32'h00);
    $display("test second reset done");
    finish_test();
  end
endmodule : tb_iucf_config
